/* File: include/oss_pkg.sv */
/*
  Constants shared by the octal switch output control block: register map,
  field positions, reset values and link check settings.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package oss_pkg;

  // Sizes
  localparam int          OSS_NSW       = 8;
  localparam int          OSS_AW        = 8;
  localparam int          OSS_DW        = 32;
  localparam int          OSS_NIRQ      = 4;
  localparam int          OSS_NSUP      = 4;

  // Register byte offsets
  localparam logic [7:0]  OSS_OFS_OUT   = 8'h00;
  localparam logic [7:0]  OSS_OFS_STAT  = 8'h04;
  localparam logic [7:0]  OSS_OFS_MASK  = 8'h08;
  localparam logic [7:0]  OSS_OFS_GERR  = 8'h0c;
  localparam logic [7:0]  OSS_OFS_PINS  = 8'h10;
  localparam logic [7:0]  OSS_OFS_TXCRC = 8'h14;

  // Interrupt status bits
  localparam int          OSS_IRQ_LINK  = 0;
  localparam int          OSS_IRQ_SUP   = 1;
  localparam int          OSS_IRQ_UPD   = 2;
  localparam int          OSS_IRQ_TXC   = 3;

  // Global error register bits
  localparam int          OSS_GE_VDD    = 0;
  localparam int          OSS_GE_VA     = 1;
  localparam int          OSS_GE_VL     = 2;
  localparam int          OSS_GE_VINT   = 3;

  // Reset values
  localparam logic [7:0]  OSS_OUT_RST   = 8'h00;
  localparam logic [3:0]  OSS_MASK_RST  = 4'h0;
  localparam logic [3:0]  OSS_GERR_RST  = 4'h8;

  // Link check polynomial and seed
  localparam logic [7:0]  OSS_CRC_POLY  = 8'h07;
  localparam logic [7:0]  OSS_CRC_INIT  = 8'h00;

  // AXI responses
  localparam logic [1:0]  OSS_RESP_OK   = 2'h0;
  localparam logic [1:0]  OSS_RESP_ERR  = 2'h2;

endpackage

/* File: core/oss_crc.sv */
/*
  Byte-wide running check code over a byte stream.
  Assumes clr and en are one-cycle strobes synchronous to clk.
*/
`timescale 1ns/1ps
module oss_crc
  import oss_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Byte stream
  input  wire logic       clr,
  input  wire logic       en,
  input  wire logic [7:0] data,
  // Running code
  output logic      [7:0] crc
);
  import oss_pkg::*;

  typedef struct packed {
    logic [7:0] crc;
  } oss_crc_s;

  oss_crc_s q_ff;
  oss_crc_s nxt_q;

  // Shift one byte through the polynomial, clear wins over a new byte
  always_comb begin
    logic [7:0] c;
    c = q_ff.crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ OSS_CRC_POLY) : (c << 1);
    end
    nxt_q = q_ff;
    if (clr) begin
      nxt_q.crc = OSS_CRC_INIT;
    end else if (en) begin
      nxt_q.crc = c;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      q_ff.crc <= OSS_CRC_INIT;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign crc = q_ff.crc;
endmodule

/* File: core/oss_out_latch.sv */
/*
  Update latch between the output state register and the switches.
  Assumes the strobe pin is synchronous to clk.
*/
`timescale 1ns/1ps
module oss_out_latch
  import oss_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Controls
  input  wire logic               strobe,
  input  wire logic [OSS_NSW-1:0] reg_val,
  // Applied pattern
  output logic      [OSS_NSW-1:0] applied
);
  import oss_pkg::*;

  typedef struct packed {
    logic               strobe_prev;
    logic [OSS_NSW-1:0] applied;
  } oss_latch_s;

  oss_latch_s q_ff;
  oss_latch_s nxt_q;

  // Load on the rising edge, follow the register while strobe stays high
  always_comb begin
    nxt_q = q_ff;
    nxt_q.strobe_prev = strobe;
    if (strobe && !q_ff.strobe_prev) begin
      nxt_q.applied = reg_val;
    end else if (strobe) begin
      nxt_q.applied = reg_val;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign applied = q_ff.applied;
endmodule

/* File: core/oss_top.sv */
/*
  Control and status logic of an octal high-side switch: AXI4-Lite registers,
  update strobe handling, enable gating, alert, link error and ready pins.
  Assumes all pins synchronous to clk; supply good levels come from monitors.
*/
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module oss_top
  import oss_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               srst,
  // AXI4-Lite write
  input  wire logic [OSS_AW-1:0]  s_awaddr,
  input  wire logic               s_awvalid,
  output logic                    s_awready,
  input  wire logic [OSS_DW-1:0]  s_wdata,
  input  wire logic [3:0]         s_wstrb,
  input  wire logic               s_wvalid,
  output logic                    s_wready,
  output logic      [1:0]         s_bresp,
  output logic                    s_bvalid,
  input  wire logic               s_bready,
  // AXI4-Lite read
  input  wire logic [OSS_AW-1:0]  s_araddr,
  input  wire logic               s_arvalid,
  output logic                    s_arready,
  output logic      [OSS_DW-1:0]  s_rdata,
  output logic      [1:0]         s_rresp,
  output logic                    s_rvalid,
  input  wire logic               s_rready,
  // Control pins
  input  wire logic               en,
  input  wire logic               output_update_strobe,
  input  wire logic               crc_check_select,
  // Supply monitors
  input  wire logic               vdd_ok,
  input  wire logic               va_ok,
  input  wire logic               vl_ok,
  input  wire logic               vint_ok,
  // Serial link byte streams
  input  wire logic [7:0]         rx_data,
  input  wire logic               rx_valid,
  input  wire logic               rx_last,
  input  wire logic [7:0]         tx_data,
  input  wire logic               tx_valid,
  input  wire logic               tx_last,
  output logic      [7:0]         tx_crc,
  // Switch outputs
  output logic      [OSS_NSW-1:0] sw_on,
  output logic      [OSS_NSW-1:0] sw_oe,
  output logic                    ow_src_en,
  // Open-drain pins
  input  wire logic               fault_i,
  output logic                    fault_o,
  output logic                    fault_oe,
  input  wire logic               link_error_flag_n_i,
  output logic                    link_error_flag_n_o,
  output logic                    link_error_flag_n_oe,
  input  wire logic               ready_i,
  output logic                    ready_o,
  output logic                    ready_oe,
  // Interrupt
  output logic                    irq
);
  import oss_pkg::*;

  typedef struct packed {
    logic [OSS_AW-1:0]   aw_addr;
    logic                aw_got;
    logic [OSS_DW-1:0]   w_data;
    logic [3:0]          w_strb;
    logic                w_got;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [OSS_DW-1:0]   rdata;
    logic [1:0]          rresp;
    logic [OSS_NSW-1:0]  out_state;
    logic [OSS_NIRQ-1:0] status;
    logic [OSS_NIRQ-1:0] mask;
    logic [OSS_NSUP-1:0] gerr;
    logic [OSS_NSW-1:0]  sw_on;
    logic [OSS_NSW-1:0]  sw_oe;
    logic                ow_src_en;
    logic                fault_oe;
    logic                link_oe;
    logic                ready_oe;
    logic                irq;
    logic [7:0]          tx_crc;
    logic [OSS_NSW-1:0]  applied_prev;
  } oss_state_s;

  oss_state_s q_ff;
  oss_state_s nxt_q;

  logic                rst_all;
  logic                sup_ok;
  logic [OSS_NSW-1:0]  applied;
  logic [7:0]          rx_crc;
  logic [7:0]          tx_run;
  logic                rx_bad;
  logic                wr_go;
  logic                rd_go;
  logic [OSS_NSUP-1:0] sup_low;

  // Register supply loss acts as a reset of all state
  assign rst_all = srst | ~vint_ok;
  assign sup_ok  = vdd_ok & va_ok & vl_ok & vint_ok;
  assign sup_low = {~vint_ok, ~vl_ok, ~va_ok, ~vdd_ok};

  // Update latch; one register bit per switch, set means on
  oss_out_latch u_latch (
    .clk     (clk),
    .rst     (rst_all),
    .strobe  (output_update_strobe),
    .reg_val (q_ff.out_state),
    .applied (applied)
  );

  // Running code over received bytes, the last byte carries the sender's code
  oss_crc u_rx_crc (
    .clk  (clk),
    .rst  (rst_all),
    .clr  (rx_valid & rx_last),
    .en   (rx_valid & ~rx_last & crc_check_select),
    .data (rx_data),
    .crc  (rx_crc)
  );

  // Running code over transmitted bytes
  oss_crc u_tx_crc (
    .clk  (clk),
    .rst  (rst_all),
    .clr  (tx_valid & tx_last),
    .en   (tx_valid & ~tx_last & crc_check_select),
    .data (tx_data),
    .crc  (tx_run)
  );

  // Mismatch only counts while checking is selected
  assign rx_bad = rx_valid & rx_last & crc_check_select & (rx_data != rx_crc);
  assign wr_go  = q_ff.aw_got & q_ff.w_got & ~q_ff.bvalid;
  assign rd_go  = s_arvalid & q_ff.arready;

  // Next state: bus slave, registers, events and pins
  always_comb begin
    logic [OSS_NIRQ-1:0] ev;
    logic [OSS_NIRQ-1:0] w1c;
    logic                gerr_rd;
    nxt_q   = q_ff;
    ev      = '0;
    w1c     = '0;
    gerr_rd = 1'b0;
    // Address and data taken in either order
    if (s_awvalid && q_ff.awready) begin
      nxt_q.aw_addr = s_awaddr;
      nxt_q.aw_got  = 1'b1;
    end
    if (s_wvalid && q_ff.wready) begin
      nxt_q.w_data = s_wdata;
      nxt_q.w_strb = s_wstrb;
      nxt_q.w_got  = 1'b1;
    end
    // Perform the write once both halves are in
    if (wr_go) begin
      nxt_q.aw_got = 1'b0;
      nxt_q.w_got  = 1'b0;
      nxt_q.bvalid = 1'b1;
      nxt_q.bresp  = OSS_RESP_OK;
      case (q_ff.aw_addr)
        OSS_OFS_OUT: begin
          if (q_ff.w_strb[0]) begin
            nxt_q.out_state = q_ff.w_data[OSS_NSW-1:0];
          end
        end
        OSS_OFS_STAT: begin
          if (q_ff.w_strb[0]) begin
            w1c = q_ff.w_data[OSS_NIRQ-1:0];
          end
        end
        OSS_OFS_MASK: begin
          if (q_ff.w_strb[0]) begin
            nxt_q.mask = q_ff.w_data[OSS_NIRQ-1:0];
          end
        end
        OSS_OFS_GERR, OSS_OFS_PINS, OSS_OFS_TXCRC: begin
          nxt_q.bresp = OSS_RESP_OK;
        end
        default: begin
          nxt_q.bresp = OSS_RESP_ERR;
        end
      endcase
    end
    if (q_ff.bvalid && s_bready) begin
      nxt_q.bvalid = 1'b0;
    end
    nxt_q.awready = ~nxt_q.aw_got & ~nxt_q.bvalid;
    nxt_q.wready  = ~nxt_q.w_got & ~nxt_q.bvalid;
    // Read: data one cycle after the address is taken
    if (rd_go) begin
      nxt_q.arready = 1'b0;
      nxt_q.rvalid  = 1'b1;
      nxt_q.rresp   = OSS_RESP_OK;
      nxt_q.rdata   = '0;
      case (s_araddr)
        OSS_OFS_OUT: begin
          nxt_q.rdata[OSS_NSW-1:0] = q_ff.out_state;
        end
        OSS_OFS_STAT: begin
          nxt_q.rdata[OSS_NIRQ-1:0] = q_ff.status;
        end
        OSS_OFS_MASK: begin
          nxt_q.rdata[OSS_NIRQ-1:0] = q_ff.mask;
        end
        OSS_OFS_GERR: begin
          nxt_q.rdata[OSS_NSUP-1:0] = q_ff.gerr;
          gerr_rd = 1'b1;
        end
        OSS_OFS_PINS: begin
          nxt_q.rdata[13:0] = {fault_i, link_error_flag_n_i, ready_i,
                               crc_check_select, output_update_strobe, en,
                               applied};
        end
        OSS_OFS_TXCRC: begin
          nxt_q.rdata[7:0] = q_ff.tx_crc;
        end
        default: begin
          nxt_q.rresp = OSS_RESP_ERR;
        end
      endcase
    end else if (q_ff.rvalid && s_rready) begin
      nxt_q.rvalid  = 1'b0;
      nxt_q.arready = 1'b1;
    end else if (!q_ff.rvalid) begin
      nxt_q.arready = 1'b1;
    end
    // Latched supply faults clear on read, a new fault in that cycle wins
    nxt_q.gerr = (gerr_rd ? '0 : q_ff.gerr) | sup_low;
    // Events set sticky bits, set wins over write-one-to-clear
    ev[OSS_IRQ_LINK] = rx_bad;
    ev[OSS_IRQ_SUP]  = |(sup_low & ~q_ff.gerr);
    ev[OSS_IRQ_UPD]  = applied != q_ff.applied_prev;
    ev[OSS_IRQ_TXC]  = tx_valid & tx_last & crc_check_select;
    nxt_q.status = (q_ff.status & ~w1c) | ev;
    nxt_q.applied_prev = applied;
    // Code of the finished outgoing frame
    if (tx_valid && tx_last && crc_check_select) begin
      nxt_q.tx_crc = tx_run;
    end
    // Switches: enable and supplies gate the applied pattern
    nxt_q.sw_on = (en && sup_ok) ? applied : '0;
    nxt_q.sw_oe = {OSS_NSW{en & sup_ok}};
    nxt_q.ow_src_en = sup_ok;
    // Alert, link error and irq pins follow the next register contents; ready follows vint_ok and vl_ok
    nxt_q.irq      = |(nxt_q.status & nxt_q.mask);
    nxt_q.fault_oe = (|(nxt_q.status & nxt_q.mask))
                   | ((|nxt_q.gerr) & nxt_q.mask[OSS_IRQ_SUP]);
    nxt_q.link_oe  = nxt_q.status[OSS_IRQ_LINK];
    nxt_q.ready_oe = ~(vint_ok & vl_ok);
  end

  // State register; srst or register supply loss forces reset contents and drives ready high
  always_ff @(posedge clk) begin
    if (rst_all) begin
      q_ff           <= '0;
      q_ff.out_state <= OSS_OUT_RST;
      q_ff.mask      <= OSS_MASK_RST;
      q_ff.gerr      <= OSS_GERR_RST;
      q_ff.ready_oe  <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Outputs straight from the state register; fault_o, link_error_flag_n_o and ready_o are constants
  assign s_awready            = q_ff.awready;
  assign s_wready             = q_ff.wready;
  assign s_bvalid             = q_ff.bvalid;
  assign s_bresp              = q_ff.bresp;
  assign s_arready            = q_ff.arready;
  assign s_rvalid             = q_ff.rvalid;
  assign s_rdata              = q_ff.rdata;
  assign s_rresp              = q_ff.rresp;
  assign tx_crc               = q_ff.tx_crc;
  assign sw_on                = q_ff.sw_on;
  assign sw_oe                = q_ff.sw_oe;
  assign ow_src_en            = q_ff.ow_src_en;
  assign fault_o              = 1'b0;
  assign fault_oe             = q_ff.fault_oe;
  assign link_error_flag_n_o  = 1'b0;
  assign link_error_flag_n_oe = q_ff.link_oe;
  assign ready_o              = 1'b1;
  assign ready_oe             = q_ff.ready_oe;
  assign irq                  = q_ff.irq;

  // Sequences for the strobe and link checks
  sequence strobe_rise_s;
    !output_update_strobe ##1 output_update_strobe;
  endsequence

  sequence strobe_held_s;
    output_update_strobe ##1 output_update_strobe;
  endsequence

  sequence bad_frame_s;
    rx_bad;
  endsequence

  en_off_a: assert property (@(posedge clk) disable iff (rst_all)
    !en |=> (sw_oe == '0) && (sw_on == '0))
    else $error("switches not off after enable low");

  override_a: assert property (@(posedge clk) disable iff (rst_all)
    (!en && output_update_strobe) ##1 !en |=> sw_on == '0)
    else $error("strobe overrode enable low");

  strobe_load_a: assert property (@(posedge clk) disable iff (rst_all)
    strobe_rise_s |=> applied == $past(q_ff.out_state))
    else $error("strobe edge did not load register");

  hold_low_a: assert property (@(posedge clk) disable iff (rst_all)
    !output_update_strobe ##1 !output_update_strobe |-> $stable(applied))
    else $error("outputs changed while strobe low");

  transparent_a: assert property (@(posedge clk) disable iff (rst_all)
    strobe_held_s ##1 (output_update_strobe && en && sup_ok)
      |=> sw_on == $past(q_ff.out_state, 2))
    else $error("transparent update missed");

  crc_off_a: assert property (@(posedge clk) disable iff (rst_all)
    (rx_valid && rx_last && !crc_check_select && !q_ff.status[OSS_IRQ_LINK])
      |=> !q_ff.status[OSS_IRQ_LINK])
    else $error("link error flagged with checking off");

  fault_a: assert property (@(posedge clk) disable iff (rst_all)
    (|(q_ff.status & q_ff.mask)) |-> fault_oe)
    else $error("alert not pulled low");

  link_err_a: assert property (@(posedge clk) disable iff (rst_all)
    bad_frame_s |=> link_error_flag_n_oe [*2])
    else $error("link error pin not pulled low");

  ready_a: assert property (@(posedge clk) disable iff (srst)
    (vint_ok && vl_ok) [*2] |-> !ready_oe)
    else $error("ready not passive with supplies good");

  gerr_hold_a: assert property (@(posedge clk) disable iff (rst_all)
    (q_ff.gerr != '0) && !(rd_go && s_araddr == OSS_OFS_GERR) |=> q_ff.gerr != '0)
    else $error("supply fault cleared without read");

  sup_off_a: assert property (@(posedge clk) disable iff (srst)
    !sup_ok && vint_ok |=> (sw_on == '0) && !ow_src_en)
    else $error("switches on during lockout");

endmodule

/* File: bench/oss_far_end.sv */
/*
  Board side of the status pins: pull resistors on the open-drain lines.
  Assumes the block drives each pin only through its output enable.
*/
`timescale 1ns/1ps
module oss_far_end (
  // Alert pin
  input  wire logic fault_o,
  input  wire logic fault_oe,
  output logic      fault_n,
  // Link error pin
  input  wire logic link_o,
  input  wire logic link_oe,
  output logic      link_n,
  // Ready pin
  input  wire logic ready_o,
  input  wire logic ready_oe,
  output logic      ready_n
);
  // Pull-ups hold the alert and link error lines high once released
  assign fault_n = fault_oe ? fault_o : 1'b1;
  assign link_n  = link_oe ? link_o : 1'b1;
  // Pull-down makes a released ready line read as ready
  assign ready_n = ready_oe ? ready_o : 1'b0;
endmodule

/* File: bench/oss_top_bench.sv */
/*
  Self-checking bench of the switch control block: register, strobe,
  enable, supply, alert, interrupt and link check scenarios.
  Assumes the block answers on its AXI4-Lite port and pins are clk-synchronous.
*/
`timescale 1ns/1ps
module oss_top_bench;
  import oss_pkg::*;
  logic               clk, srst, en, output_update_strobe, crc_check_select;
  logic               s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic               s_arvalid, s_arready, s_rvalid, s_rready;
  logic               vdd_ok, va_ok, vl_ok, vint_ok, irq, ow_src_en;
  logic               rx_valid, rx_last, tx_valid, tx_last;
  logic               fault_i, fault_o, fault_oe, ready_i, ready_o, ready_oe;
  logic               link_error_flag_n_i, link_error_flag_n_o, link_error_flag_n_oe;
  logic [OSS_AW-1:0]  s_awaddr, s_araddr;
  logic [OSS_DW-1:0]  s_wdata, s_rdata, rd;
  logic [3:0]         s_wstrb;
  logic [1:0]         s_bresp, s_rresp, rsp;
  logic [7:0]         rx_data, tx_data, tx_crc, good;
  logic [OSS_NSW-1:0] sw_on, sw_oe;
  int                 miscompares, num_checks;

  // Block under test and its pull resistors
  oss_top oss_top_i (
    .clk, .srst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .en, .output_update_strobe,
    .crc_check_select, .vdd_ok, .va_ok, .vl_ok, .vint_ok, .rx_data, .rx_valid,
    .rx_last, .tx_data, .tx_valid, .tx_last, .tx_crc, .sw_on, .sw_oe, .ow_src_en,
    .fault_i, .fault_o, .fault_oe, .link_error_flag_n_i, .link_error_flag_n_o,
    .link_error_flag_n_oe, .ready_i, .ready_o, .ready_oe, .irq);
  oss_far_end oss_far_end_i (
    .fault_o(fault_o), .fault_oe(fault_oe), .fault_n(fault_i),
    .link_o(link_error_flag_n_o), .link_oe(link_error_flag_n_oe),
    .link_n(link_error_flag_n_i), .ready_o(ready_o), .ready_oe(ready_oe),
    .ready_n(ready_i));

  // 50 MHz clock
  always #10 clk = ~clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Write one word; valids drop as each channel is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
      if (s_bvalid === 1'b1) break;
    end
    s_bready <= 1'b0;
    rsp = s_bresp;
    if (n == 40) chk("write answer", 1, 0);
    if (n == 40) stop_test();
  endtask

  // Read one word into rd and rsp
  task automatic rdw(input logic [7:0] a);
    int n;
    @(posedge clk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
      if (s_rvalid === 1'b1) break;
    end
    s_rready <= 1'b0;
    rd  = s_rdata;
    rsp = s_rresp;
    if (n == 40) chk("read answer", 1, 0);
    if (n == 40) stop_test();
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    rdw(a);
    chk(what, exp, rd);
  endtask

  // Expected check code of two data bytes, MSB first
  function automatic logic [7:0] crc8(input logic [7:0] a, input logic [7:0] b);
    logic [7:0]  c;
    logic [15:0] s;
    c = OSS_CRC_INIT;
    s = {a, b};
    for (int k = 15; k >= 0; k--) c = {c[6:0], 1'b0} ^ ((c[7] ^ s[k]) ? OSS_CRC_POLY : 8'h00);
    return c;
  endfunction

  // Same frame on both streams: two data bytes, then the code byte
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] code);
    logic [7:0] byt [3];
    byt = '{b0, b1, code};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      rx_data  <= byt[i];
      tx_data  <= byt[i];
      rx_valid <= 1'b1;
      tx_valid <= 1'b1;
      rx_last  <= (i == 2);
      tx_last  <= (i == 2);
    end
    @(posedge clk);
    {rx_valid, tx_valid, rx_last, tx_last} <= 4'h0;
    rx_data <= ~code;
    tx_data <= ~code;
  endtask

  // Main sequence
  initial begin
    {clk, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h00;
    {output_update_strobe, crc_check_select, rx_valid, rx_last, tx_valid, tx_last} = 6'h00;
    {srst, en, vdd_ok, va_ok, vl_ok, vint_ok} = 6'h3f;
    {s_awaddr, s_araddr, s_wdata, rx_data, tx_data} = '0;
    s_wstrb = 4'hf;
    miscompares = 0;
    num_checks = 0;
    good = crc8(8'h12, 8'h34);
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    cyc(2);
    chk("ready pin", 0, ready_i);
    rchk("gerr reset", OSS_OFS_GERR, OSS_GERR_RST);
    rchk("gerr cleared", OSS_OFS_GERR, 0);
    rchk("out reset", OSS_OFS_OUT, OSS_OUT_RST);
    rchk("mask reset", OSS_OFS_MASK, OSS_MASK_RST);
    rdw(8'h40);
    chk("unmapped resp", OSS_RESP_ERR, rsp);
    wr(OSS_OFS_TXCRC, 32'hff);
    chk("ro write resp", OSS_RESP_OK, rsp);
    rchk("ro code", OSS_OFS_TXCRC, 0);
    wr(8'h40, 32'h1);
    chk("unmapped write resp", OSS_RESP_ERR, rsp);
    // Strobe low keeps the switches; pattern written before the strobe rises
    wr(OSS_OFS_OUT, 32'ha5);
    cyc(3);
    chk("sw_on held", 0, sw_on);
    output_update_strobe <= 1'b1;
    cyc(3);
    chk("sw_on loaded", 8'ha5, sw_on);
    chk("sw_oe on", 8'hff, sw_oe);
    wr(OSS_OFS_OUT, 32'h3c);
    cyc(3);
    chk("sw_on transparent", 8'h3c, sw_on);
    output_update_strobe <= 1'b0;
    wr(OSS_OFS_OUT, 32'hff);
    cyc(3);
    chk("sw_on strobe low", 8'h3c, sw_on);
    // Lane 0 disabled: the pattern register keeps its contents
    s_wstrb <= 4'h0;
    wr(OSS_OFS_OUT, 32'h00);
    s_wstrb <= 4'hf;
    rchk("out lane 0 only", OSS_OFS_OUT, 32'hff);
    rchk("pins", OSS_OFS_PINS, 32'h313c);
    // Enable low wins over a strobe edge
    en <= 1'b0;
    output_update_strobe <= 1'b1;
    cyc(3);
    chk("sw_on en low", 0, sw_on);
    chk("sw_oe en low", 0, sw_oe);
    en <= 1'b1;
    cyc(3);
    chk("sw_on en high", 8'hff, sw_on);
    // Pattern change event: masked, unmasked, cleared
    chk("irq masked", 0, irq);
    wr(OSS_OFS_MASK, 32'h4);
    cyc(1);
    chk("irq raised", 1, irq);
    wr(OSS_OFS_STAT, 32'h4);
    cyc(1);
    chk("irq cleared", 0, irq);
    // Supply dip with the supply fault enabled on the alert
    wr(OSS_OFS_MASK, 32'h2);
    va_ok <= 1'b0;
    vl_ok <= 1'b0;
    cyc(3);
    chk("sw_oe lockout", 0, sw_oe);
    chk("ow off", 0, ow_src_en);
    chk("alert low", 0, fault_i);
    chk("not ready", 1, ready_i);
    chk("irq supply", 1, irq);
    va_ok <= 1'b1;
    vl_ok <= 1'b1;
    cyc(3);
    chk("ow on", 1, ow_src_en);
    wr(OSS_OFS_STAT, 32'h2);
    cyc(1);
    chk("irq w1c", 0, irq);
    chk("alert held", 0, fault_i);
    rchk("gerr va vl", OSS_OFS_GERR, 32'h6);
    cyc(2);
    chk("alert released", 1, fault_i);
    // Link code generated and checked only with select high
    crc_check_select <= 1'b1;
    frame(8'h12, 8'h34, good);
    cyc(3);
    chk("link good", 1, link_error_flag_n_i);
    rchk("tx code", OSS_OFS_TXCRC, good);
    chk("tx_crc pin", good, tx_crc);
    frame(8'h12, 8'h34, ~good);
    cyc(3);
    chk("link error", 0, link_error_flag_n_i);
    wr(OSS_OFS_STAT, 32'h1);
    cyc(2);
    chk("link clear", 1, link_error_flag_n_i);
    crc_check_select <= 1'b0;
    frame(8'h56, 8'h78, 8'h00);
    cyc(3);
    chk("link unchecked", 1, link_error_flag_n_i);
    rchk("tx code kept", OSS_OFS_TXCRC, good);
    // Register supply loss
    vint_ok <= 1'b0;
    cyc(3);
    chk("ready high", 1, ready_i);
    chk("sw_oe vint", 0, sw_oe);
    vint_ok <= 1'b1;
    cyc(3);
    chk("ready back", 0, ready_i);
    rchk("out lost", OSS_OFS_OUT, OSS_OUT_RST);
    rchk("gerr vint", OSS_OFS_GERR, 32'h8);
    // Main supply dip: switches and sources off, ready kept, fault latched
    vdd_ok <= 1'b0;
    cyc(3);
    chk("sw_oe vdd", 0, sw_oe);
    chk("ow off vdd", 0, ow_src_en);
    chk("ready vdd", 0, ready_i);
    vdd_ok <= 1'b1;
    cyc(2);
    chk("sw_oe vdd back", 8'hff, sw_oe);
    rchk("gerr vdd", OSS_OFS_GERR, 32'h1);
    stop_test();
  end
endmodule
